// File: verilog/radio_baseband_map.vh
// constants of the 2.4 GHz O-QPSK baseband: rates, sync, AGC, RSSI, CCA
// assumes one 125 MHz system clock and a signed 8-bit IF converter input
`ifndef RADIO_BASEBAND_MAP_VH
`define RADIO_BASEBAND_MAP_VH
`define CLK_MHZ 125
`define CLK_WRAP 7'h7D
`define ADC_MSPS 12
`define SAMP_PER_CHIP 6
`define CHIP_PHASE 3'h3
`define SAMP_PER_QSYM 48
`define RSSI_WIN_SAMP (8 * 4 * `SAMP_PER_QSYM)
`define SEQ_ZERO 32'hD9C3522E
`define ODD_CHIPS 32'h55555555
`define SYNC_THR 6'h04
`define SFD_LO 4'h7
`define SFD_HI 4'hA
`define GAIN_RST 5'h10
`define GAIN_MAX 5'h1F
`define AGC_HI 8'h60
`define AGC_LO 8'h18
`define RSSI_OFS 8'hA6
`define CFG_CCA 3'h0
`define CFG_LNA 3'h1
`define CFG_FILT 3'h2
`define CFG_MOD 3'h3
`define CFG_TX 3'h4
`define CCA_RST 2'h0
`define CAL_RST 8'h80
`endif

// File: verilog/radio_baseband_cca_spreader.v
// receive despreader, AGC, RSSI, CCA and transmit spreader of the radio
// assumes MAC and configuration logic on CLK_SYS; converter data from pins
`timescale 1ns/1ns
`include "radio_baseband_map.vh"
module radio_baseband_cca_spreader (
    input wire CLK_SYS,
    input wire RST,
    input wire [7:0] ADC_DATA,
    output reg [4:0] IF_GAIN,
    output reg [3:0] RX_SYM,
    output reg RX_SYM_VALID,
    input wire RX_SYM_READY,
    output reg RX_OVERRUN,
    output reg RX_SYNC,
    input wire RX_PKT_END,
    output reg [7:0] RSSI_WIN,
    output reg RSSI_WIN_STB,
    output reg [7:0] RSSI_PKT,
    output reg RSSI_PKT_STB,
    input wire [7:0] CCA_RSSI_THR,
    output reg CCA_BUSY,
    input wire PRIV,
    input wire CFG_WR,
    input wire [2:0] CFG_ADDR,
    input wire [7:0] CFG_WDATA,
    output reg CFG_DENIED,
    output reg [1:0] CCA_MODE,
    output reg [7:0] LNA_CAL,
    output reg [7:0] FILT_CAL,
    output reg [7:0] MOD_CAL,
    output reg [7:0] TX_CAL,
    input wire TX_EN,
    input wire [3:0] TX_SYM,
    input wire TX_SYM_VALID,
    output wire TX_SYM_READY,
    output reg TX_CHIP_I,
    output reg TX_CHIP_Q,
    output reg TX_CHIP_STB,
    output reg TX_ACTIVE
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_SFD = 2'h2;
    localparam ST_DATA = 2'h3;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [31:0] spread;
        input [3:0] sym;
        reg [63:0] dbl;
        begin
            dbl = {`SEQ_ZERO, `SEQ_ZERO} >> {sym[2:0], 2'b00};
            spread = dbl[31:0] ^ (sym[3] ? `ODD_CHIPS : 32'h00000000);
        end
    endfunction

    function [5:0] popcnt;
        input [31:0] x;
        integer k;
        begin
            popcnt = 6'h00;
            for (k = 0; k < 32; k = k + 1) begin
                popcnt = popcnt + {5'h00, x[k]};
            end
        end
    endfunction

    function [7:0] rssi_of;
        input [17:0] sum;
        input [4:0] gain;
        integer k;
        reg [4:0] lvl;
        begin
            lvl = 5'h00;
            for (k = 0; k < 18; k = k + 1) begin
                if (sum[k]) begin
                    lvl = k[4:0];
                end
            end
            rssi_of = {lvl, 2'b00} + {2'b00, lvl, 1'b0}
                - {2'b00, gain, 1'b0} + `RSSI_OFS;
        end
    endfunction

    // ------------------------------------------------------------
    // converter input and 12 Msps sample strobe
    // ------------------------------------------------------------
    reg [7:0] adc_s1_q, adc_s2_q, samp_q;
    reg [6:0] acc_q;
    reg samp_stb_q;
    wire [7:0] acc_sum = {1'b0, acc_q} + `ADC_MSPS;
    wire [7:0] mag = samp_q[7] ? (8'h00 - samp_q) : samp_q;

    always @(posedge CLK_SYS) begin
        adc_s1_q <= ADC_DATA;
        adc_s2_q <= adc_s1_q;
        if (RST) begin
            acc_q <= 7'h00;
            samp_stb_q <= 1'b0;
            samp_q <= 8'h00;
        end else begin
            samp_stb_q <= (acc_sum >= `CLK_MHZ);
            if (acc_sum >= `CLK_MHZ) begin
                acc_q <= acc_sum[6:0] - `CLK_WRAP;
                samp_q <= adc_s2_q;
            end else begin
                acc_q <= acc_sum[6:0];
            end
        end
    end

    // ------------------------------------------------------------
    // chip timing and chip window
    // ------------------------------------------------------------
    reg [2:0] pcnt_q;
    reg [31:0] chips_q;
    reg chip_new_q;
    reg [1:0] st_q;
    wire rx_on = ~TX_EN;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            pcnt_q <= 3'h0;
            chips_q <= 32'h00000000;
            chip_new_q <= 1'b0;
        end else begin
            chip_new_q <= samp_stb_q && pcnt_q == `CHIP_PHASE && rx_on;
            if (samp_stb_q) begin
                pcnt_q <= (pcnt_q == `SAMP_PER_CHIP - 1) ? 3'h0
                    : pcnt_q + 3'h1;
                if (pcnt_q == `CHIP_PHASE && rx_on) begin
                    chips_q <= {chips_q[30:0], ~samp_q[7]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // despreading: nearest of the sixteen sequences
    // ------------------------------------------------------------
    reg [3:0] best_sym;
    reg [5:0] best_dist;
    reg [5:0] d;
    integer s;
    wire [5:0] dist0 = popcnt(chips_q ^ `SEQ_ZERO);

    always @* begin
        best_sym = 4'h0;
        best_dist = 6'h3F;
        d = 6'h00;
        for (s = 0; s < 16; s = s + 1) begin
            d = popcnt(chips_q ^ spread(s[3:0]));
            if (d < best_dist) begin
                best_dist = d;
                best_sym = s[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // preamble sync and symbol hand-over
    // ------------------------------------------------------------
    reg [4:0] ccnt_q;
    wire sym_end = chip_new_q && st_q != ST_IDLE && ccnt_q == 5'h1F;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            st_q <= ST_IDLE;
            ccnt_q <= 5'h00;
            RX_SYM <= 4'h0;
            RX_SYM_VALID <= 1'b0;
            RX_OVERRUN <= 1'b0;
            RX_SYNC <= 1'b0;
        end else begin
            RX_OVERRUN <= 1'b0;
            if (RX_SYM_VALID && RX_SYM_READY) begin
                RX_SYM_VALID <= 1'b0;
            end
            if (chip_new_q) begin
                ccnt_q <= ccnt_q + 5'h01;
            end
            if (RX_PKT_END || !rx_on) begin
                st_q <= ST_IDLE;
            end else if (chip_new_q && st_q == ST_IDLE) begin
                if (dist0 <= `SYNC_THR) begin
                    st_q <= ST_PRE;
                    ccnt_q <= 5'h00;
                end
            end else if (sym_end) begin
                case (st_q)
                    ST_PRE: begin
                        if (best_dist > `SYNC_THR) begin
                            st_q <= ST_IDLE;
                        end else if (best_sym == `SFD_LO) begin
                            st_q <= ST_SFD;
                        end else if (best_sym != 4'h0) begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_SFD: begin
                        st_q <= (best_sym == `SFD_HI) ? ST_DATA : ST_IDLE;
                    end
                    ST_DATA: begin
                        RX_SYM <= best_sym;
                        RX_SYM_VALID <= 1'b1;
                        RX_OVERRUN <= RX_SYM_VALID && !RX_SYM_READY;
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
            RX_SYNC <= st_q != ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // gain control
    // ------------------------------------------------------------
    reg [5:0] qcnt_q;
    reg [7:0] peak_q;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            qcnt_q <= 6'h00;
            peak_q <= 8'h00;
            IF_GAIN <= `GAIN_RST;
        end else if (samp_stb_q) begin
            if (qcnt_q == `SAMP_PER_QSYM - 1) begin
                qcnt_q <= 6'h00;
                peak_q <= 8'h00;
                if (st_q == ST_IDLE && rx_on) begin
                    if (peak_q > `AGC_HI && IF_GAIN != 5'h00) begin
                        IF_GAIN <= IF_GAIN - 5'h01;
                    end else if (peak_q < `AGC_LO && IF_GAIN != `GAIN_MAX)
                    begin
                        IF_GAIN <= IF_GAIN + 5'h01;
                    end
                end
            end else begin
                qcnt_q <= qcnt_q + 6'h01;
                if (mag > peak_q) begin
                    peak_q <= mag;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // signal strength
    // ------------------------------------------------------------
    reg [10:0] wcnt_q;
    reg [17:0] sum_q;
    reg [17:0] last_q;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            wcnt_q <= 11'h000;
            sum_q <= 18'h00000;
            last_q <= 18'h00000;
            RSSI_WIN <= 8'h00;
            RSSI_WIN_STB <= 1'b0;
            RSSI_PKT <= 8'h00;
            RSSI_PKT_STB <= 1'b0;
        end else begin
            RSSI_WIN_STB <= 1'b0;
            RSSI_PKT_STB <= RX_PKT_END;
            if (RX_PKT_END) begin
                RSSI_PKT <= rssi_of(last_q | sum_q, IF_GAIN);
            end
            if (samp_stb_q) begin
                if (wcnt_q == `RSSI_WIN_SAMP - 1) begin
                    wcnt_q <= 11'h000;
                    sum_q <= 18'h00000;
                    last_q <= sum_q;
                    RSSI_WIN <= rssi_of(sum_q, IF_GAIN);
                    RSSI_WIN_STB <= 1'b1;
                end else begin
                    wcnt_q <= wcnt_q + 11'h001;
                    sum_q <= sum_q + {10'h000, mag};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // clear-channel assessment
    // ------------------------------------------------------------
    wire cs_busy = st_q != ST_IDLE;
    wire ed_busy = $signed(RSSI_WIN) > $signed(CCA_RSSI_THR);

    always @(posedge CLK_SYS) begin
        if (RST) begin
            CCA_BUSY <= 1'b0;
        end else begin
            case (CCA_MODE)
                2'h0: CCA_BUSY <= cs_busy | ed_busy;
                2'h1: CCA_BUSY <= ed_busy;
                2'h2: CCA_BUSY <= cs_busy;
                2'h3: CCA_BUSY <= cs_busy & ed_busy;
                default: CCA_BUSY <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration and calibration
    // ------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (RST) begin
            CCA_MODE <= `CCA_RST;
            LNA_CAL <= `CAL_RST;
            FILT_CAL <= `CAL_RST;
            MOD_CAL <= `CAL_RST;
            TX_CAL <= `CAL_RST;
            CFG_DENIED <= 1'b0;
        end else begin
            CFG_DENIED <= CFG_WR && !PRIV;
            if (CFG_WR && PRIV) begin
                case (CFG_ADDR)
                    `CFG_CCA: CCA_MODE <= CFG_WDATA[1:0];
                    `CFG_LNA: LNA_CAL <= CFG_WDATA;
                    `CFG_FILT: FILT_CAL <= CFG_WDATA;
                    `CFG_MOD: MOD_CAL <= CFG_WDATA;
                    `CFG_TX: TX_CAL <= CFG_WDATA;
                    default: CFG_DENIED <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // transmit spreader
    // ------------------------------------------------------------
    reg [31:0] txsr_q;
    reg [4:0] tcnt_q;
    reg tbusy_q;
    assign TX_SYM_READY = TX_ACTIVE && !tbusy_q;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            txsr_q <= 32'h00000000;
            tcnt_q <= 5'h00;
            tbusy_q <= 1'b0;
            TX_CHIP_I <= 1'b0;
            TX_CHIP_Q <= 1'b0;
            TX_CHIP_STB <= 1'b0;
            TX_ACTIVE <= 1'b0;
        end else begin
            TX_ACTIVE <= TX_EN;
            TX_CHIP_STB <= 1'b0;
            if (TX_SYM_READY && TX_SYM_VALID) begin
                txsr_q <= spread(TX_SYM);
                tcnt_q <= 5'h00;
                tbusy_q <= 1'b1;
            end else if (tbusy_q && samp_stb_q && pcnt_q == 3'h0) begin
                if (tcnt_q[0]) begin
                    TX_CHIP_Q <= txsr_q[31];
                end else begin
                    TX_CHIP_I <= txsr_q[31];
                end
                TX_CHIP_STB <= 1'b1;
                txsr_q <= {txsr_q[30:0], 1'b0};
                tcnt_q <= tcnt_q + 5'h01;
                tbusy_q <= tcnt_q != 5'h1F && TX_EN;
            end else if (!TX_EN) begin
                tbusy_q <= 1'b0;
            end
        end
    end
endmodule // radio_baseband_cca_spreader

// File: testbench/rbb_assertions.sv
// port checker of the baseband: CCA, gain, config and transmit handshake
// assumes one clock CLK_SYS and synchronous active-high RST
`timescale 1ns/1ns
module rbb_assertions (
    input wire CLK_SYS,
    input wire RST,
    input wire [4:0] IF_GAIN,
    input wire RX_SYNC,
    input wire [7:0] RSSI_WIN,
    input wire [7:0] CCA_RSSI_THR,
    input wire CCA_BUSY,
    input wire PRIV,
    input wire CFG_WR,
    input wire [2:0] CFG_ADDR,
    input wire [7:0] CFG_WDATA,
    input wire CFG_DENIED,
    input wire [1:0] CCA_MODE,
    input wire TX_EN,
    input wire TX_SYM_VALID,
    input wire TX_SYM_READY,
    input wire TX_CHIP_STB,
    input wire TX_ACTIVE
);
    // --------------------------------
    // helper terms
    // --------------------------------
    wire energy = $signed(RSSI_WIN) > $signed(CCA_RSSI_THR);
    wire busy_x = CCA_MODE == 2'h0 ? (energy | RX_SYNC) :
        CCA_MODE == 2'h1 ? energy :
        CCA_MODE == 2'h2 ? RX_SYNC : (energy & RX_SYNC);
    wire mode_wr = CFG_WR & PRIV & (CFG_ADDR == 3'h0);
    wire [1:0] mode_wd = CFG_WDATA[1:0];
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    sequence s_steady;
        ($stable(CCA_MODE) && $stable(RX_SYNC) && $stable(RSSI_WIN)
            && $stable(CCA_RSSI_THR))[*2];
    endsequence
    sequence s_take;
        TX_SYM_VALID && TX_SYM_READY;
    endsequence
    sequence s_first_chip;
        !TX_SYM_READY ##[1:80] TX_CHIP_STB;
    endsequence
    // --------------------------------
    // assertions
    // --------------------------------
    a_cca_mode_map:
        assert property (s_steady |-> CCA_BUSY == busy_x)
        else $error("busy flag wrong for mode");
    a_gain_frozen:
        assert property (RX_SYNC && $past(RX_SYNC) |-> $stable(IF_GAIN))
        else $error("gain moved while synced");
    a_gain_step:
        assert property ($stable(IF_GAIN) || IF_GAIN == $past(IF_GAIN)
            + 5'h01 || IF_GAIN == $past(IF_GAIN) - 5'h01)
        else $error("gain jumped");
    a_cfg_denied:
        assert property (CFG_WR && !PRIV |=> CFG_DENIED)
        else $error("denial missing");
    a_mode_locked:
        assert property (!mode_wr |=> $stable(CCA_MODE))
        else $error("mode changed without write");
    a_mode_write:
        assert property (mode_wr |=> CCA_MODE == $past(mode_wd))
        else $error("mode not written");
    a_pa_high:
        assert property (TX_EN |=> TX_ACTIVE)
        else $error("indicator low in transmit");
    a_pa_low:
        assert property (!TX_EN |=> !TX_ACTIVE)
        else $error("indicator high in receive");
    a_tx_take:
        assert property (s_take |=> s_first_chip)
        else $error("no chip after symbol");
endmodule // rbb_assertions

bind radio_baseband_cca_spreader rbb_assertions u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .IF_GAIN(IF_GAIN), .RX_SYNC(RX_SYNC),
    .RSSI_WIN(RSSI_WIN), .CCA_RSSI_THR(CCA_RSSI_THR), .CCA_BUSY(CCA_BUSY),
    .PRIV(PRIV), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR),
    .CFG_WDATA(CFG_WDATA), .CFG_DENIED(CFG_DENIED), .CCA_MODE(CCA_MODE),
    .TX_EN(TX_EN), .TX_SYM_VALID(TX_SYM_VALID),
    .TX_SYM_READY(TX_SYM_READY), .TX_CHIP_STB(TX_CHIP_STB),
    .TX_ACTIVE(TX_ACTIVE));

// File: testbench/rf_front_model.sv
// front-end model: converter samples from 32-chip symbol sequences
// assumes a 125 MHz clock; 62 or 63 clocks a chip gives 2 Mchip/s
`timescale 1ns/1ns
`include "radio_baseband_map.vh"
module rf_front_model #(
    parameter [7:0] AMP = 8'h70
) (
    input wire clk,
    output logic [7:0] adc = 8'h02
);
    logic busy_q = 1'b0;
    logic [7:0] lvl_q = 8'h00;
    int nchip = 0;
    // --------------------------------
    // chip sequence of a symbol
    // --------------------------------
    function automatic logic [31:0] chip_seq(input logic [3:0] s);
        logic [31:0] b;
        b = `SEQ_ZERO;
        b = (b >> (4 * s[2:0])) | (b << (32 - 4 * s[2:0]));
        return s[3] ? b ^ `ODD_CHIPS : b;
    endfunction
    // idle: weak input whose sign flips every clock
    always @(posedge clk) begin
        adc <= busy_q ? lvl_q : (adc == 8'h02 ? 8'hFE : 8'h02);
    end
    task automatic send_sym(input logic [3:0] s);
        logic [31:0] q;
        q = chip_seq(s);
        for (int k = 0; k < 32; k++) begin
            @(posedge clk);
            busy_q <= 1'b1;
            lvl_q <= q[31 - k] ? AMP : -AMP;
            repeat (nchip[0] ? 62 : 61) @(posedge clk);
            nchip++;
        end
    endtask
    task automatic quiet;
        @(posedge clk);
        busy_q <= 1'b0;
    endtask
endmodule // rf_front_model

// File: testbench/tb.sv
// bench of the baseband: config, gain control, receive, CCA, transmit
// assumes the front-end model feeds ADC_DATA; the bench plays the MAC
`timescale 1ns/1ns
`include "radio_baseband_map.vh"
module tb;
    logic CLK_SYS = 1'b0, RST = 1'b1, RX_SYM_READY = 1'b0;
    logic RX_PKT_END = 1'b0, PRIV = 1'b0, CFG_WR = 1'b0, TX_EN = 1'b0;
    logic TX_SYM_VALID = 1'b0;
    logic [7:0] CCA_RSSI_THR = 8'h7F, CFG_WDATA = 8'h00;
    logic [2:0] CFG_ADDR = 3'h0;
    logic [3:0] TX_SYM = 4'h0;
    wire [7:0] ADC_DATA, RSSI_WIN, LNA_CAL, FILT_CAL, MOD_CAL, TX_CAL;
    wire [4:0] IF_GAIN;
    wire [3:0] RX_SYM;
    wire [1:0] CCA_MODE;
    wire RX_SYM_VALID, RX_SYNC, RSSI_PKT_STB, CCA_BUSY, CFG_DENIED;
    wire TX_SYM_READY, TX_CHIP_I, TX_CHIP_Q, TX_CHIP_STB, TX_ACTIVE;
    logic [51:0] pkt = {32'h0, 4'h7, 4'hA, 4'h1, 4'h8, 4'hF};
    logic [3:0] rxq[$];
    int n_errors = 0, cmp_count = 0;
    radio_baseband_cca_spreader u_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .ADC_DATA(ADC_DATA),
        .IF_GAIN(IF_GAIN), .RX_SYM(RX_SYM), .RX_SYM_VALID(RX_SYM_VALID),
        .RX_SYM_READY(RX_SYM_READY), .RX_OVERRUN(), .RX_SYNC(RX_SYNC),
        .RX_PKT_END(RX_PKT_END), .RSSI_WIN(RSSI_WIN), .RSSI_WIN_STB(),
        .RSSI_PKT(), .RSSI_PKT_STB(RSSI_PKT_STB),
        .CCA_RSSI_THR(CCA_RSSI_THR), .CCA_BUSY(CCA_BUSY), .PRIV(PRIV),
        .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
        .CFG_DENIED(CFG_DENIED), .CCA_MODE(CCA_MODE), .LNA_CAL(LNA_CAL),
        .FILT_CAL(FILT_CAL), .MOD_CAL(MOD_CAL), .TX_CAL(TX_CAL),
        .TX_EN(TX_EN), .TX_SYM(TX_SYM), .TX_SYM_VALID(TX_SYM_VALID),
        .TX_SYM_READY(TX_SYM_READY), .TX_CHIP_I(TX_CHIP_I),
        .TX_CHIP_Q(TX_CHIP_Q), .TX_CHIP_STB(TX_CHIP_STB),
        .TX_ACTIVE(TX_ACTIVE));
    rf_front_model u_rf (.clk(CLK_SYS), .adc(ADC_DATA));
    // --------------------------------
    // clock, stalling MAC, monitor
    // --------------------------------
    initial begin
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        RX_SYM_READY <= !RX_SYM_READY;
        if (RX_SYM_VALID === 1'b1 && RX_SYM_READY === 1'b1) begin
            rxq.push_back(RX_SYM);
        end
    end
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic cfg(input logic p, input logic [2:0] a, input [7:0] d);
        @(posedge CLK_SYS);
        PRIV <= p;
        CFG_WR <= 1'b1;
        CFG_ADDR <= a;
        CFG_WDATA <= d;
        @(posedge CLK_SYS);
        CFG_WR <= 1'b0;
        #1;
        chk(CFG_DENIED === !p, "denial flag");
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_cfg;
        chk(CCA_MODE === `CCA_RST, "mode reset");
        chk(IF_GAIN === `GAIN_RST, "gain reset");
        cfg(1'b1, `CFG_LNA, 8'h11);
        cfg(1'b1, `CFG_FILT, 8'h22);
        cfg(1'b1, `CFG_MOD, 8'h33);
        cfg(1'b1, `CFG_TX, 8'h44);
        cfg(1'b1, 3'h5, 8'h03);
        chk({LNA_CAL, FILT_CAL, MOD_CAL, TX_CAL} === 32'h11223344, "cal");
        cfg(1'b0, `CFG_CCA, 8'h02);
        cfg(1'b0, `CFG_LNA, 8'h99);
        chk(CCA_MODE === 2'h0 && LNA_CAL === 8'h11, "locked write");
    endtask
    task automatic t_cca(input logic cs);
        logic x;
        for (int m = 0; m < 8; m++) begin
            @(posedge CLK_SYS);
            CCA_RSSI_THR <= m[2] ? 8'h80 : 8'h7F;
            cfg(1'b1, `CFG_CCA, {6'h0, m[1:0]});
            repeat (3) @(posedge CLK_SYS);
            #1;
            x = m[1:0] == 0 ? cs | m[2] : m[1:0] == 1 ? m[2] : cs & ~m[0];
            x = m[1:0] == 3 ? cs & m[2] : x;
            chk(CCA_BUSY === x, "busy for mode");
        end
    endtask
    task automatic t_rx;
        logic [4:0] g;
        logic s;
        int n;
        g = IF_GAIN;
        repeat (1200) @(posedge CLK_SYS);
        chk(IF_GAIN > g, "gain kept on weak input");
        fork
            for (int i = 0; i < 13; i++) u_rf.send_sym(pkt[51 - 4 * i -: 4]);
        join_none
        for (n = 0; RX_SYNC !== 1'b1 && n < 20000; n++) @(posedge CLK_SYS);
        chk(RX_SYNC === 1'b1, "no preamble lock");
        t_cca(1'b1);
        g = IF_GAIN;
        wait fork;
        repeat (100) @(posedge CLK_SYS);
        chk(IF_GAIN === g, "gain moved in packet");
        RX_PKT_END <= 1'b1;
        @(posedge CLK_SYS);
        RX_PKT_END <= 1'b0;
        s = 1'b0;
        repeat (2) begin
            #1 s = s | RSSI_PKT_STB;
            @(posedge CLK_SYS);
        end
        chk(s === 1'b1, "no packet-end strength");
        u_rf.quiet();
        while (rxq.size() > 0 && rxq[0] === 4'h0) void'(rxq.pop_front());
        chk(rxq.size() == 3, "symbol count");
        for (int i = 0; i < 3 && i < rxq.size(); i++) begin
            chk(rxq[i] === pkt[11 - 4 * i -: 4], "rx symbol");
        end
    endtask
    task automatic t_tx;
        logic [31:0] q;
        int n;
        @(posedge CLK_SYS);
        TX_EN <= 1'b1;
        for (int j = 0; j < 4; j++) begin
            q = u_rf.chip_seq(4'h5 * j[3:0]);
            @(posedge CLK_SYS);
            TX_SYM <= 4'h5 * j[3:0];
            TX_SYM_VALID <= 1'b1;
            n = 0;
            #1;
            while (TX_SYM_READY !== 1'b1 && n < 5000) begin
                @(posedge CLK_SYS);
                #1 n++;
            end
            @(posedge CLK_SYS);
            TX_SYM_VALID <= 1'b0;
            chk(TX_ACTIVE === 1'b1, "indicator low");
            for (int k = 0; k < 32; k++) begin
                n = 0;
                do begin
                    @(posedge CLK_SYS);
                    #1 n++;
                end while (TX_CHIP_STB !== 1'b1 && n < 200);
                chk((k[0] ? TX_CHIP_Q : TX_CHIP_I) === q[31 - k], "chip");
            end
        end
        @(posedge CLK_SYS);
        TX_EN <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1 chk(TX_ACTIVE === 1'b0, "indicator high");
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(8 * 80000);
        n_errors++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        #1 t_cfg();
        t_cca(1'b0);
        t_rx();
        t_tx();
        summarize();
    end
endmodule // tb
